// ---- hw/cprs_pkg.sv ----
// Package for the card punch/read sequencer: counts, reset values, stacker opcode.
// Assumes all users refer to names as cprs_pkg::name.
package cprs_pkg;
   localparam int                ROW_STAGES     = 6;
   localparam int                GROUP_WIDTH    = 4;
   localparam int                REV_WIDTH      = 2;
   localparam logic [1:0]        REV_RESET      = 2'h0;
   localparam logic [1:0]        REV_ONE        = 2'h1;
   localparam logic [1:0]        REV_TWO        = 2'h2;
   localparam logic [1:0]        REV_THREE      = 2'h3;
   localparam logic [3:0]        GROUP_RESET    = 4'h0;
   localparam logic [3:0]        GROUP_ONE      = 4'h1;
   localparam logic [3:0]        GROUP_PUNCH_FIRST = 4'h2;
   localparam logic [3:0]        GROUP_PUNCH_END = 4'h6;
   localparam logic [3:0]        GROUP_READ_END = 4'hA;
   localparam logic [5:0]        ROW_ONE        = 6'h01;
   localparam logic [5:0]        ROW_RESET      = 6'h00;
   localparam logic [5:0]        STACKER_OPCODE = 6'h39;
endpackage

// ---- hw/cprs_sync3.sv ----
// Three-stage synchroniser; output changes once stages two and three agree.
// Assumes the input is asynchronous to clk.
module cprs_sync3 (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic din,
   output logic      dout
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule

// ---- hw/cprs_row_ring.sv ----
// Six-stage row ring with field flag; one-hot, last stage feeds the first.
// Assumes step and preset are single-cycle pulses on clk.
module cprs_row_ring #(
   parameter int STAGES = cprs_pkg::ROW_STAGES
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              presetOne,
   input  wire logic              fieldRestore,
   input  wire logic              step,
   output logic [STAGES-1:0]      ring_r,
   output logic                   lowerField_r
);
   wire lastTap = ring_r[STAGES-1];
   wire wrapNow = step && lastTap;

   if (STAGES < 2) begin : gBadStages
      $error("Row ring needs at least two stages");
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ring_r <= STAGES'(1);
      end else if (presetOne) begin
         ring_r <= STAGES'(1);
      end else if (step) begin
         ring_r <= {ring_r[STAGES-2:0], lastTap};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         lowerField_r <= 1'b0;
      end else if (fieldRestore) begin
         lowerField_r <= 1'b0;
      end else if (wrapNow) begin
         lowerField_r <= !lowerField_r;
      end
   end
endmodule

// ---- hw/cprs_sequencer.sv ----
// Card punch/read sequencer: revolution, row and column-group counters,
// punch start synchroniser, end-of-setup detector and stacker select.
// Assumes word/pulse timing strobes arrive as one-cycle enables on clk;
// only the cam pulse is asynchronous. General clear is resetn.

module cprs_sequencer (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        pulseTime,
   input  wire logic        rawCamAnglePulse,
   input  wire logic        alternateWordPhase,
   input  wire logic        interlockSet,
   input  wire logic        revolutionEnd,
   input  wire logic        xSentinel,
   input  wire logic        rowsDoneSentinel,
   input  wire logic        punchShiftSet,
   input  wire logic        readerControlSet,
   input  wire logic        head1WriteRestore,
   input  wire logic        capacitorsReady,
   input  wire logic        readActive,
   input  wire logic        keyboardMode,
   input  wire logic        keyboardGroupStep,
   input  wire logic [5:0]  opcode,
   input  wire logic        opcodeValid,
   output logic             setupStartDirect_r,
   output logic             setupStartStored_r,
   output logic             punchSetup_r,
   output logic             interlock3_r,
   output logic             goCycle_r,
   output logic             stackerOne_r,
   output logic             readOutEnable_r,
   output logic             marginCountTwo_r,
   output logic             columnDriveReset_r,
   output logic             groupStepPulse_r,
   output logic             evenGroupFlag_r,
   output logic             oddGroupFlag_r,
   output logic [3:0]       groupCount_r,
   output logic [5:0]       rowTaps_r,
   output logic             upperFieldFlag_r,
   output logic             lowerFieldFlag_r,
   output logic [11:0]      rowTransferStrobe_r,
   output logic             capacitorEnergize_r,
   output logic             setupDone_r,
   output logic             punchGateActive_r
);
   logic [1:0] revCount_r;
   logic [1:0] revCount_nxt;
   logic [3:0] groupCount_nxt;
   logic       camLatch_r;
   logic       camSync_r;
   logic       syncDelay_r;
   logic       finalStore_r;
   logic       xStored_r;
   logic [5:0] ring;
   logic       lowerField;

   function automatic logic [3:0] groupInc(input logic [3:0] g, input logic [3:0] last);
      groupInc = (g == last) ? cprs_pkg::GROUP_ONE : 4'(g + 4'h1);
   endfunction

   // Cam pulse is from the mechanism, so it is synchronised first
   wire camSynced;

   cprs_sync3 camSyncer (
      .clk    (clk),
      .resetn (resetn),
      .din    (rawCamAnglePulse),
      .dout   (camSynced)
   );

   // Revolution decodes
   wire revOne   = revCount_r == cprs_pkg::REV_ONE;
   wire revTwo   = revCount_r == cprs_pkg::REV_TWO;
   wire revThree = revCount_r == cprs_pkg::REV_THREE;

   // Punch-setup entry: direct (cam while interlocked) or stored (cam seen earlier)
   wire startDirect = pulseTime && interlock3_r && camSync_r && !punchSetup_r;
   wire startStored = pulseTime && interlock3_r && finalStore_r && !punchSetup_r
                      && !startDirect;
   wire setupStart  = startDirect || startStored;
   // Preset on entry to revolution one only; a held preset blocks shift steps
   wire groupAtReset = groupCount_r == cprs_pkg::GROUP_RESET;
   wire groupPreset = pulseTime && punchSetup_r && revOne && groupAtReset;
   wire groupClear  = pulseTime && punchSetup_r && revThree;
   // Set once per third revolution, so the row-step restore sticks
   wire driveResetSet = groupClear && !groupAtReset;
   wire rowStepPunch = pulseTime && punchSetup_r && xSentinel && revThree;
   wire endSetup    = pulseTime && punchSetup_r && xStored_r && rowsDoneSentinel
                      && revThree && ring[0] && !lowerField;
   wire readStep    = pulseTime && readActive && head1WriteRestore;
   wire groupAtTen  = groupCount_r == cprs_pkg::GROUP_READ_END;
   wire rowPresetRead = pulseTime && readActive && readerControlSet;
   wire rowStepRead = readStep && groupAtTen;
   // Keyboard step counts only in keyboard mode
   wire kbStep      = pulseTime && keyboardMode && keyboardGroupStep;
   wire groupStepPunch = pulseTime && punchSetup_r && punchShiftSet && !groupClear;
   wire groupAdvance = groupStepPunch || readStep || kbStep;
   wire stackerDecode = opcodeValid && (opcode == cprs_pkg::STACKER_OPCODE);
   wire stackerRelease = pulseTime && goCycle_r && revolutionEnd;
   // Punch transfer uses groups two to six; count runs one step ahead
   wire punchWindow = (groupCount_nxt >= cprs_pkg::GROUP_PUNCH_FIRST)
                      && (groupCount_nxt <= cprs_pkg::GROUP_PUNCH_END);
   wire groupEvenNxt = (groupCount_nxt != cprs_pkg::GROUP_RESET) && !groupCount_nxt[0];
   wire groupOddNxt  = groupCount_nxt[0];
   wire [11:0] rowStrobeNxt = lowerField ? {ring, 6'h00} : {6'h00, ring};

   // Revolution counter
   always_comb begin
      revCount_nxt = revCount_r;
      if (endSetup) begin
         revCount_nxt = cprs_pkg::REV_RESET;
      end else if (setupStart) begin
         revCount_nxt = cprs_pkg::REV_TWO;
      end else if (pulseTime && punchSetup_r && revolutionEnd) begin
         revCount_nxt = (revThree) ? cprs_pkg::REV_ONE : 2'(revCount_r + 2'h1);
      end
   end

   // Column-group counter
   always_comb begin
      groupCount_nxt = groupCount_r;
      if (rowPresetRead) begin
         groupCount_nxt = cprs_pkg::GROUP_ONE;
      end else if (groupClear) begin
         groupCount_nxt = cprs_pkg::GROUP_RESET;
      end else if (groupPreset) begin
         groupCount_nxt = cprs_pkg::GROUP_ONE;
      end else if (groupAdvance) begin
         groupCount_nxt = groupInc(groupCount_r, cprs_pkg::GROUP_READ_END);
      end
   end

   // Revolution and group counters move only on pulse timing, defined on clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         revCount_r   <= cprs_pkg::REV_RESET;
         groupCount_r <= cprs_pkg::GROUP_RESET;
      end else begin
         revCount_r   <= revCount_nxt;
         groupCount_r <= groupCount_nxt;
      end
   end

   // Cam latch: set wins over the delayed clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         camLatch_r  <= 1'b0;
         camSync_r   <= 1'b0;
         syncDelay_r <= 1'b0;
      end else if (pulseTime) begin
         camLatch_r  <= camSynced || (camLatch_r && !syncDelay_r);
         camSync_r   <= camLatch_r && !alternateWordPhase;
         syncDelay_r <= camSync_r;
      end
   end

   // Final-store flag lets the first punch start without a cam pulse
   always_ff @(posedge clk) begin
      if (!resetn) begin
         finalStore_r <= 1'b1;
      end else if (pulseTime) begin
         if (punchSetup_r) begin
            finalStore_r <= 1'b0;
         end else if (camSync_r && !interlock3_r) begin
            finalStore_r <= 1'b1;
         end
      end
   end

   // Setup and interlock; a fresh interlock set beats the end restore
   always_ff @(posedge clk) begin
      if (!resetn) begin
         punchSetup_r <= 1'b0;
         interlock3_r <= 1'b0;
      end else if (pulseTime) begin
         if (endSetup) begin
            punchSetup_r <= 1'b0;
            interlock3_r <= interlockSet;
         end else begin
            punchSetup_r <= punchSetup_r || setupStart;
            interlock3_r <= interlock3_r || interlockSet;
         end
      end
   end

   // Go flag and stored X sentinel
   always_ff @(posedge clk) begin
      if (!resetn) begin
         goCycle_r <= 1'b0;
         xStored_r <= 1'b0;
      end else if (pulseTime) begin
         goCycle_r <= endSetup || (goCycle_r && !setupStart);
         if (setupStart) begin
            xStored_r <= 1'b0;
         end else if (xSentinel && punchSetup_r) begin
            xStored_r <= 1'b1;
         end
      end
   end

   // One-cycle pulses
   always_ff @(posedge clk) begin
      if (!resetn) begin
         setupStartDirect_r <= 1'b0;
         setupStartStored_r <= 1'b0;
         groupStepPulse_r   <= 1'b0;
         setupDone_r        <= 1'b0;
      end else begin
         setupStartDirect_r <= startDirect;
         setupStartStored_r <= startStored;
         groupStepPulse_r   <= groupAdvance;
         setupDone_r        <= endSetup;
      end
   end

   // Stacker relay; a select in the release cycle still wins
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stackerOne_r <= 1'b0;
      end else if (stackerDecode) begin
         stackerOne_r <= 1'b1;
      end else if (stackerRelease) begin
         stackerOne_r <= 1'b0;
      end
   end

   // Revolution decodes and column-drive reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         readOutEnable_r    <= 1'b0;
         marginCountTwo_r   <= 1'b0;
         columnDriveReset_r <= 1'b0;
      end else begin
         readOutEnable_r  <= punchSetup_r && revOne;
         marginCountTwo_r <= revTwo;
         if (driveResetSet) begin
            columnDriveReset_r <= 1'b1;
         end else if (rowStepPunch) begin
            columnDriveReset_r <= 1'b0;
         end
      end
   end

   // Punch gate and capacitor energize
   always_ff @(posedge clk) begin
      if (!resetn) begin
         punchGateActive_r   <= 1'b0;
         capacitorEnergize_r <= 1'b0;
      end else begin
         punchGateActive_r   <= punchSetup_r && punchWindow;
         capacitorEnergize_r <= (readActive && capacitorsReady) || punchSetup_r
                                || setupStart;
      end
   end

   // Row ring; field flag restored only at setup start, so it stays upper after
   cprs_row_ring #(
      .STAGES (cprs_pkg::ROW_STAGES)
   ) rowRing (
      .clk          (clk),
      .resetn       (resetn),
      .presetOne    (setupStart || rowPresetRead),
      .fieldRestore (setupStart),
      .step         (rowStepPunch || rowStepRead),
      .ring_r       (ring),
      .lowerField_r (lowerField)
   );

   // Decodes registered so every output is a flip-flop
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rowTaps_r           <= cprs_pkg::ROW_RESET;
         upperFieldFlag_r    <= 1'b1;
         lowerFieldFlag_r    <= 1'b0;
         rowTransferStrobe_r <= 12'h000;
         evenGroupFlag_r     <= 1'b0;
         oddGroupFlag_r      <= 1'b0;
      end else begin
         rowTaps_r        <= ring;
         upperFieldFlag_r <= !lowerField;
         lowerFieldFlag_r <= lowerField;
         rowTransferStrobe_r <= capacitorEnergize_r ? rowStrobeNxt : 12'h000;
         evenGroupFlag_r  <= groupEvenNxt;
         oddGroupFlag_r   <= groupOddNxt;
      end
   end
endmodule

// ---- tb/cprs_sequencer_properties.sv ----
// Port-level checker for the card punch/read sequencer.
// Assumes a bind from the bench top; general clear is resetn, active low.
module cprs_sequencer_properties (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [5:0]  opcode,
   input wire logic        opcodeValid,
   input wire logic        punchSetup_r,
   input wire logic        interlock3_r,
   input wire logic        goCycle_r,
   input wire logic        stackerOne_r,
   input wire logic        readOutEnable_r,
   input wire logic        marginCountTwo_r,
   input wire logic        evenGroupFlag_r,
   input wire logic        oddGroupFlag_r,
   input wire logic [3:0]  groupCount_r,
   input wire logic [5:0]  rowTaps_r,
   input wire logic        upperFieldFlag_r,
   input wire logic        lowerFieldFlag_r,
   input wire logic [11:0] rowTransferStrobe_r,
   input wire logic        setupDone_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_field; upperFieldFlag_r != lowerFieldFlag_r; endproperty
   a_field: assert property (p_field) else $error("field flags agree");
   property p_ring; $onehot0(rowTaps_r); endproperty
   a_ring: assert property (p_ring) else $error("row taps not one-hot");
   property p_strobe; $onehot0(rowTransferStrobe_r); endproperty
   a_strobe: assert property (p_strobe) else $error("several row strobes");
   property p_group; groupCount_r <= 4'hA; endproperty
   a_group: assert property (p_group) else $error("group count past ten");
   property p_parity; !(evenGroupFlag_r && oddGroupFlag_r); endproperty
   a_parity: assert property (p_parity) else $error("odd and even together");
   property p_margin; !(marginCountTwo_r && readOutEnable_r); endproperty
   a_margin: assert property (p_margin) else $error("count two with read-out");
   property p_stacker;
      opcodeValid && opcode == 6'h39 && !goCycle_r |-> ##[1:2] stackerOne_r;
   endproperty
   a_stacker: assert property (p_stacker) else $error("stacker not selected");
   property p_start;
      $rose(punchSetup_r) |-> ##[0:3] (rowTaps_r == 6'h01 && upperFieldFlag_r);
   endproperty
   a_start: assert property (p_start) else $error("setup start not row one");
   property p_done;
      setupDone_r |-> ##[0:2] (goCycle_r && !punchSetup_r && !interlock3_r);
   endproperty
   a_done: assert property (p_done) else $error("end of setup incomplete");
endmodule

// ---- tb/cprs_punch_model.sv ----
// Reader-punch model: timing cam pulse on request, counts card cycles.
// Assumes camKick is a one-cycle request on clk; cam line idles low.
module cprs_punch_model (
   input  wire logic clk,
   input  wire logic camKick,
   input  wire logic goRelay,
   output logic      camPulse,
   output int        cardCycles
);
   timeunit 1ns;
   timeprecision 1ps;
   int   camLeft = 0;
   int   cycles  = 0;
   logic goSeen  = 1'b0;
   // Cam held well past the three-stage sync window
   always @(posedge clk) begin
      camLeft <= camKick ? 8 : (camLeft > 0 ? camLeft - 1 : 0);
      goSeen <= goRelay;
      if (goRelay && !goSeen) cycles <= cycles + 1;
   end
   assign camPulse   = camLeft > 0;
   assign cardCycles = cycles;
endmodule

// ---- tb/card_punch_read_sequencer_bench.sv ----
// Bench for the sequencer: reset, stacker, keyboard, read, punch setup, cam.
// Assumes hw/ files compiled first; inputs move at the falling edge.
module card_punch_read_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ILK = 8'h01, REV = 8'h02, XS = 8'h04, DONE = 8'h08;
   localparam logic [7:0] PSH = 8'h10, RDC = 8'h20, H1W = 8'h40, KBS = 8'h80;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic pulseTime = 1'b0;
   logic [7:0] pl = 8'h00;
   logic alternateWordPhase = 1'b0;
   logic capacitorsReady = 1'b0;
   logic readActive = 1'b0;
   logic keyboardMode = 1'b0;
   logic [5:0] opcode = 6'h00;
   logic opcodeValid = 1'b0;
   logic camKick = 1'b0;
   logic rawCamAnglePulse;
   int cardCycles;
   int mismatches = 0;
   int tests_run = 0;
   int steps = 0;
   int storedStarts = 0;
   int directStarts = 0;
   logic setupStartDirect_r, setupStartStored_r, punchSetup_r, interlock3_r, goCycle_r;
   logic stackerOne_r, readOutEnable_r, marginCountTwo_r, columnDriveReset_r;
   logic groupStepPulse_r, evenGroupFlag_r, oddGroupFlag_r, upperFieldFlag_r;
   logic lowerFieldFlag_r, capacitorEnergize_r, setupDone_r, punchGateActive_r;
   logic [3:0] groupCount_r;
   logic [5:0] rowTaps_r;
   logic [11:0] rowTransferStrobe_r;
   wire logic interlockSet, revolutionEnd, xSentinel, rowsDoneSentinel;
   wire logic punchShiftSet, readerControlSet, head1WriteRestore, keyboardGroupStep;
   assign {keyboardGroupStep, head1WriteRestore, readerControlSet, punchShiftSet,
           rowsDoneSentinel, xSentinel, revolutionEnd, interlockSet} = pl;
   always #5 clk = ~clk;
   // Pulse timing every other cycle, so each two-cycle pulse is seen once
   always @(negedge clk) pulseTime <= ~pulseTime;
   always @(posedge clk) begin
      if (groupStepPulse_r === 1'b1) steps <= steps + 1;
      if (setupStartStored_r === 1'b1) storedStarts <= storedStarts + 1;
      if (setupStartDirect_r === 1'b1) directStarts <= directStarts + 1;
   end
   cprs_sequencer u_cprs_sequencer (
      .clk                 (clk),
      .resetn              (resetn),
      .pulseTime           (pulseTime),
      .rawCamAnglePulse    (rawCamAnglePulse),
      .alternateWordPhase  (alternateWordPhase),
      .interlockSet        (interlockSet),
      .revolutionEnd       (revolutionEnd),
      .xSentinel           (xSentinel),
      .rowsDoneSentinel    (rowsDoneSentinel),
      .punchShiftSet       (punchShiftSet),
      .readerControlSet    (readerControlSet),
      .head1WriteRestore   (head1WriteRestore),
      .capacitorsReady     (capacitorsReady),
      .readActive          (readActive),
      .keyboardMode        (keyboardMode),
      .keyboardGroupStep   (keyboardGroupStep),
      .opcode              (opcode),
      .opcodeValid         (opcodeValid),
      .setupStartDirect_r  (setupStartDirect_r),
      .setupStartStored_r  (setupStartStored_r),
      .punchSetup_r        (punchSetup_r),
      .interlock3_r        (interlock3_r),
      .goCycle_r           (goCycle_r),
      .stackerOne_r        (stackerOne_r),
      .readOutEnable_r     (readOutEnable_r),
      .marginCountTwo_r    (marginCountTwo_r),
      .columnDriveReset_r  (columnDriveReset_r),
      .groupStepPulse_r    (groupStepPulse_r),
      .evenGroupFlag_r     (evenGroupFlag_r),
      .oddGroupFlag_r      (oddGroupFlag_r),
      .groupCount_r        (groupCount_r),
      .rowTaps_r           (rowTaps_r),
      .upperFieldFlag_r    (upperFieldFlag_r),
      .lowerFieldFlag_r    (lowerFieldFlag_r),
      .rowTransferStrobe_r (rowTransferStrobe_r),
      .capacitorEnergize_r (capacitorEnergize_r),
      .setupDone_r         (setupDone_r),
      .punchGateActive_r   (punchGateActive_r)
   );
   cprs_punch_model u_cprs_punch_model (.clk(clk), .camKick(camKick), .goRelay(goCycle_r),
      .camPulse(rawCamAnglePulse), .cardCycles(cardCycles));
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(input logic [7:0] m);
      pl = m;
      repeat (2) @(negedge clk);
      pl = 8'h00;
      repeat (3) @(negedge clk);
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic t_reset();
      chk("upperField", 12'(upperFieldFlag_r), 12'h001);
      chk("lowerField", 12'(lowerFieldFlag_r), 12'h000);
      chk("group", 12'(groupCount_r), 12'h000);
      chk("go", 12'(goCycle_r), 12'h000);
   endtask
   task automatic t_stacker();
      opcode = 6'h38;
      opcodeValid = 1'b1;
      repeat (3) @(negedge clk);
      chk("stackerIdle", 12'(stackerOne_r), 12'h000);
      opcode = 6'h39;
      @(negedge clk);
      opcodeValid = 1'b0;
      repeat (2) @(negedge clk);
      chk("stackerOne", 12'(stackerOne_r), 12'h001);
   endtask
   task automatic t_keyboard();
      pulse(KBS);
      chk("groupNoKbd", 12'(groupCount_r), 12'h000);
      keyboardMode = 1'b1;
      pulse(KBS);
      keyboardMode = 1'b0;
      chk("groupKbd", 12'(groupCount_r), 12'h001);
   endtask
   task automatic t_read();
      int base;
      readActive = 1'b1;
      capacitorsReady = 1'b1;
      pulse(RDC);
      chk("readGroup", 12'(groupCount_r), 12'h001);
      chk("readRow", 12'(rowTaps_r), 12'h001);
      chk("energize", 12'(capacitorEnergize_r), 12'h001);
      chk("strobe", rowTransferStrobe_r, 12'h001);
      base = steps;
      for (int g = 2; g <= 11; g++) begin
         pulse(H1W);
         chk("group", 12'(groupCount_r), (g == 11) ? 12'h001 : 12'(g));
         chk("evenFlag", 12'(evenGroupFlag_r), 12'(g % 2 == 0));
         chk("oddFlag", 12'(oddGroupFlag_r), 12'(g % 2 == 1));
         chk("row", 12'(rowTaps_r), (g == 11) ? 12'h002 : 12'h001);
      end
      chk("stepPulses", 12'(steps - base), 12'h00A);
      readActive = 1'b0;
      capacitorsReady = 1'b0;
   endtask
   task automatic t_punch();
      pulse(ILK);
      repeat (4) @(negedge clk);
      chk("setup", 12'(punchSetup_r), 12'h001);
      chk("row1", 12'(rowTaps_r), 12'h001);
      chk("upper", 12'(upperFieldFlag_r), 12'h001);
      chk("revTwo", 12'(marginCountTwo_r), 12'h001);
      chk("storedStart", 12'(storedStarts), 12'h001);
      chk("energize", 12'(capacitorEnergize_r), 12'h001);
      for (int r = 1; r <= 12; r++) begin
         pulse(REV);
         chk("revThree", 12'(groupCount_r), 12'h000);
         chk("driveSet", 12'(columnDriveReset_r), 12'h001);
         pulse(XS);
         chk("row", 12'(rowTaps_r), 12'h001 << (r % 6));
         chk("lower", 12'(lowerFieldFlag_r), 12'((r / 6) % 2));
         chk("driveClear", 12'(columnDriveReset_r), 12'h000);
         pulse(REV);
         chk("revOne", {7'h00, readOutEnable_r, groupCount_r}, 12'h011);
         pulse(PSH);
         chk("groupStep", {7'h00, punchGateActive_r, groupCount_r}, 12'h012);
         pulse(REV);
         chk("revCycle", 12'(marginCountTwo_r), 12'h001);
      end
      pulse(REV);
      pulse(XS | DONE);
      chk("go", 12'(goCycle_r), 12'h001);
      chk("ended", {10'h000, punchSetup_r, interlock3_r}, 12'h000);
      chk("upperAfter", 12'(upperFieldFlag_r), 12'h001);
      chk("cards", 12'(cardCycles), 12'h001);
   endtask
   task automatic t_cam();
      pulse(REV);
      chk("stackerRelease", 12'(stackerOne_r), 12'h000);
      pulse(ILK);
      alternateWordPhase = 1'b1;
      camKick = 1'b1;
      @(negedge clk);
      camKick = 1'b0;
      repeat (20) @(negedge clk);
      chk("phaseHigh", 12'(punchSetup_r), 12'h000);
      alternateWordPhase = 1'b0;
      repeat (20) @(negedge clk);
      chk("camStart", 12'(punchSetup_r), 12'h001);
      chk("directStart", 12'(directStarts), 12'h001);
   endtask
   initial begin
      repeat (6000) @(posedge clk);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      t_reset();
      t_stacker();
      t_keyboard();
      t_read();
      t_punch();
      t_cam();
      conclude();
   end
endmodule
bind cprs_sequencer cprs_sequencer_properties u_cprs_sequencer_properties (
   .clk                 (clk),
   .resetn              (resetn),
   .opcode              (opcode),
   .opcodeValid         (opcodeValid),
   .punchSetup_r        (punchSetup_r),
   .interlock3_r        (interlock3_r),
   .goCycle_r           (goCycle_r),
   .stackerOne_r        (stackerOne_r),
   .readOutEnable_r     (readOutEnable_r),
   .marginCountTwo_r    (marginCountTwo_r),
   .evenGroupFlag_r     (evenGroupFlag_r),
   .oddGroupFlag_r      (oddGroupFlag_r),
   .groupCount_r        (groupCount_r),
   .rowTaps_r           (rowTaps_r),
   .upperFieldFlag_r    (upperFieldFlag_r),
   .lowerFieldFlag_r    (lowerFieldFlag_r),
   .rowTransferStrobe_r (rowTransferStrobe_r),
   .setupDone_r         (setupDone_r)
);
